// ---- inc/dtk_pkg.sv ----
/*
  dtk_pkg: constants and carrier types for the dual-tone keypad generator.
  assumes a 20 MHz core clock standing in for the halved crystal reference.
*/
package dtk_pkg;
  // ----------------------------------------
  // keypad geometry
  // ----------------------------------------
  localparam int ROWS = 4;
  localparam int COLS = 4;
  localparam int SEG_STAGES = 8;
  localparam int SEGS_PER_CYCLE = 32;
  localparam int STEPS_PER_CYCLE = 16;
  // ----------------------------------------
  // clocking
  // ----------------------------------------
  localparam int CORE_HZ = 20000000;
  localparam int REF_DIV = 2;
  localparam int REF_HZ = CORE_HZ / REF_DIV;
  localparam int DIV_W = 12;
  // ----------------------------------------
  // tone table in hertz, first to fourth line
  // ----------------------------------------
  localparam int LOW_HZ [ROWS] = '{697, 770, 852, 941};
  localparam int HIGH_HZ [COLS] = '{1209, 1336, 1477, 1633};
  // divider reload counts half a divider cycle, so the divider output cycles at 16 * f
  // and its two halves give the 32 segments: reference / (2 * 16 * f), rounded
  function automatic logic [DIV_W-1:0] dtk_ratio(input int hz);
    int r;
    r = (REF_HZ + STEPS_PER_CYCLE * hz) / (2 * STEPS_PER_CYCLE * hz);
    return DIV_W'(r - 1);
  endfunction
  localparam logic [3:0] ONE_HOT_NONE = 4'h0;
  typedef enum logic [1:0] {DTK_SILENT, DTK_DUAL, DTK_LOW_ONLY, DTK_HIGH_ONLY} dtk_mode_e;
  typedef struct packed {
    logic [ROWS-1:0] row;
    logic [COLS-1:0] col;
  } dtk_keys_s;
  typedef struct packed {
    logic [ROWS-1:0] row_pull_down;
    logic [COLS-1:0] col_pull_up;
    logic [ROWS-1:0] row_oe;
    logic [COLS-1:0] col_oe;
  } dtk_pulls_s;
endpackage

// ---- rtl/dtk_keypad_gen.sv ----
/*
  dtk_keypad_gen: keypad decode, tone dividers, johnson segment counters,
  mode select and status outputs. assumes the analogue ladder and output
  stage sit outside and sum the two segment buses.
*/
`timescale 1ns/10ps
module dtk_keypad_gen
  import dtk_pkg::*;
#(
  parameter int N_ROWS = ROWS,
  parameter int N_COLS = COLS
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [N_ROWS-1:0] row_line_in,
  input wire logic [N_COLS-1:0] column_line_in,
  input wire logic tone_mode_select,
  input wire logic device_disable,
  output dtk_pulls_s pulls,
  output logic osc_enable,
  output logic [SEG_STAGES-1:0] low_segments,
  output logic [SEG_STAGES-1:0] high_segments,
  output logic low_phase,
  output logic high_phase,
  output logic tone_active,
  output logic transmit_status_out,
  output logic transmit_status_oe,
  output logic mute
);
  // ----------------------------------------
  // reset and input synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'h1};
    end
  end
  assign rst_n = rst_sync[1];

  // mode select is sampled with an idle-high default, standing in for the pull-up
  dtk_keys_s keys_meta, keys;
  logic [1:0] mode_sync, dis_sync;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      keys_meta <= '0;
      keys <= '0;
      mode_sync <= 2'h3;
      dis_sync <= 2'h0;
    end else begin
      keys_meta <= '{row: row_line_in, col: column_line_in};
      keys <= keys_meta;
      mode_sync <= {mode_sync[0], tone_mode_select};
      dis_sync <= {dis_sync[0], device_disable};
    end
  end

  logic disabled, single_ok;
  assign disabled = dis_sync[1];
  assign single_ok = mode_sync[1];

  // ----------------------------------------
  // key decode
  // ----------------------------------------
  function automatic int count_ones(input logic [3:0] v);
    int n;
    n = 0;
    for (int i = 0; i < 4; i++) begin
      n += int'(v[i]);
    end
    return n;
  endfunction

  function automatic logic [1:0] first_one(input logic [3:0] v);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  int n_rows, n_cols;
  logic any_row;
  dtk_mode_e next_mode;
  // one key lifts one row and one column
  assign n_rows = count_ones(4'(keys.row));
  assign n_cols = count_ones(4'(keys.col));
  assign any_row = keys.row != ONE_HOT_NONE[N_ROWS-1:0];

  always_comb begin
    next_mode = DTK_SILENT;
    if (disabled) begin
      next_mode = DTK_SILENT;
    end else if (n_rows == 1 && n_cols == 1) begin
      next_mode = DTK_DUAL;
    // row alone, or two keys in one row
    end else if (n_rows == 1 && (n_cols == 0 || n_cols == 2)) begin
      next_mode = single_ok ? DTK_LOW_ONLY : DTK_SILENT;
    end else if (n_rows == 2 && n_cols == 1) begin
      next_mode = single_ok ? DTK_HIGH_ONLY : DTK_SILENT;
    end
    // diagonal pairs and blocked single tones fall through silent
  end

  dtk_mode_e mode;
  logic [1:0] row_idx, col_idx;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= DTK_SILENT;
      row_idx <= 2'h0;
      col_idx <= 2'h0;
    end else begin
      mode <= next_mode;
      row_idx <= first_one(4'(keys.row));
      col_idx <= first_one(4'(keys.col));
    end
  end

  // ----------------------------------------
  // oscillator gate, pulls, status
  // ----------------------------------------
  // oscillator only with a row up and not disabled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_enable <= 1'h0;
    end else begin
      osc_enable <= any_row && !disabled;
    end
  end

  // idle pulls; on a key the decoded lines release their pulls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulls.row_pull_down <= '1;
      pulls.col_pull_up <= '1;
      pulls.row_oe <= '0;
      pulls.col_oe <= '0;
    end else if (disabled) begin
      pulls.row_pull_down <= '0;
      pulls.col_pull_up <= '0;
      pulls.row_oe <= '0;
      pulls.col_oe <= '0;
    end else begin
      pulls.row_pull_down <= ~keys.row;
      pulls.col_pull_up <= any_row ? ~keys.col : '1;
      pulls.row_oe <= '0;
      pulls.col_oe <= '0;
    end
  end

  // pressed means any row seen and not disabled
  logic pressed;
  assign pressed = any_row && !disabled;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_status_out <= 1'h1;
      transmit_status_oe <= 1'h1;
      mute <= 1'h0;
    end else begin
      transmit_status_out <= 1'h1;
      transmit_status_oe <= !pressed;
      mute <= pressed;
    end
  end

  // ----------------------------------------
  // reference halving and tone dividers
  // ----------------------------------------
  // halved reference feeds both dividers
  logic ref_tick;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_tick <= 1'h0;
    end else begin
      ref_tick <= osc_enable ? !ref_tick : 1'h0;
    end
  end

  logic low_run, high_run;
  assign low_run = mode == DTK_DUAL || mode == DTK_LOW_ONLY;
  assign high_run = mode == DTK_DUAL || mode == DTK_HIGH_ONLY;

  // reload ratios from the tone table, 32 steps per tone
  logic [DIV_W-1:0] low_ratio, high_ratio;
  always_comb begin
    low_ratio = dtk_ratio(LOW_HZ[row_idx]);
    high_ratio = dtk_ratio(HIGH_HZ[col_idx]);
  end

  logic [DIV_W-1:0] low_cnt, high_cnt;
  logic low_step, high_step;
  assign low_step = ref_tick && low_cnt == '0;
  assign high_step = ref_tick && high_cnt == '0;

  // dividers held at reload while idle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= '0;
    end else if (!low_run) begin
      low_cnt <= low_ratio;
    end else if (ref_tick) begin
      low_cnt <= low_step ? low_ratio : low_cnt - DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_cnt <= '0;
    end else if (!high_run) begin
      high_cnt <= high_ratio;
    end else if (ref_tick) begin
      high_cnt <= high_step ? high_ratio : high_cnt - DIV_W'(1);
    end
  end

  // ----------------------------------------
  // johnson counters, both phases give 32 segments
  // ----------------------------------------
  // each step is one half-period of the divider output; the phase
  // bit marks which half, so eight stages yield 32 segments per cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_segments <= '0;
      low_phase <= 1'h0;
    end else if (!low_run) begin
      low_segments <= '0;
      low_phase <= 1'h0;
    end else if (low_step) begin
      low_phase <= !low_phase;
      if (low_phase) begin
        low_segments <= {low_segments[SEG_STAGES-2:0], !low_segments[SEG_STAGES-1]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_segments <= '0;
      high_phase <= 1'h0;
    end else if (!high_run) begin
      high_segments <= '0;
      high_phase <= 1'h0;
    end else if (high_step) begin
      high_phase <= !high_phase;
      if (high_phase) begin
        high_segments <= {high_segments[SEG_STAGES-2:0], !high_segments[SEG_STAGES-1]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tone_active <= 1'h0;
    end else begin
      tone_active <= low_run || high_run;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_press;
    keys.row != '0 && !disabled;
  endsequence

  AST_MUTE_FOLLOWS_KEY: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_press |=> mute) else $error("mute not raised by key");
  AST_TRANSMIT_STATUS_OUT_FLOATS: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_press |=> !transmit_status_oe) else $error("transmit not floating on key");
  AST_TRANSMIT_STATUS_OUT_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    keys.row == '0 |=> transmit_status_oe && transmit_status_out) else $error("transmit not driven idle");
  AST_OSC_STOP: assert property (@(posedge core_clk) disable iff (!rst_n)
    keys.row == '0 |=> !osc_enable) else $error("oscillator runs without row");
  AST_DISABLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    disabled |=> !mute && !osc_enable && pulls.row_pull_down == '0) else $error("disable not honoured");
  AST_IDLE_PULLS: assert property (@(posedge core_clk) disable iff (!rst_n)
    keys.row == '0 && !disabled |=> pulls.row_pull_down == '1 && pulls.col_pull_up == '1) else $error("idle pulls");
  AST_DIAGONAL: assert property (@(posedge core_clk) disable iff (!rst_n)
    n_rows == 2 && n_cols == 2 |=> mode == DTK_SILENT) else $error("diagonal pair gave tone");
  AST_NO_SINGLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !single_ok |=> mode != DTK_LOW_ONLY && mode != DTK_HIGH_ONLY) else $error("single tone while blocked");
  AST_DUAL: assert property (@(posedge core_clk) disable iff (!rst_n)
    n_rows == 1 && n_cols == 1 && !disabled |=> mode == DTK_DUAL) else $error("dual tone missing");
  AST_HELD: assert property (@(posedge core_clk) disable iff (!rst_n)
    !low_run |=> low_segments == '0 && !low_phase) else $error("low counter not held");
endmodule

// ---- sim/dtk_key_model.sv ----
/*
  dtk_key_model: keypad stand-in for the tone generator, driven as active-high cmos logic.
  assumes the bench changes the pressed-key map and extra rows shortly after a clock edge.
*/
`timescale 1ns/10ps
module dtk_key_model (
  input wire logic [15:0] keys,
  input wire logic [3:0] extra_rows,
  output logic [3:0] row_lines,
  output logic [3:0] col_lines
);
  // ----------------------------------------
  // key matrix
  // ----------------------------------------
  // one key lifts one row, one column
  // logic drive keeps both levels, so the generator pulls never fight a floating line
  always_comb begin
    row_lines = extra_rows;
    col_lines = 4'h0;
    for (int k = 0; k < 16; k++) begin
      if (keys[k]) begin
        row_lines[k / 4] = 1'b1;
        col_lines[k % 4] = 1'b1;
      end
    end
  end
endmodule

// ---- sim/tb_dtk_keypad_gen.sv ----
/*
  tb_dtk_keypad_gen: self-checking bench for the keypad tone generator.
  assumes a 20 MHz core clock and the keypad model on the row and column lines.
*/
`timescale 1ns/10ps
module tb_dtk_keypad_gen import dtk_pkg::*;;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic tone_mode_select = 1'b1;
  logic device_disable = 1'b0;
  logic [15:0] keys = 16'h0000;
  logic [3:0] extra_rows = 4'h0;
  logic [3:0] row_lines, col_lines;
  dtk_pulls_s pulls;
  logic [7:0] low_segments, high_segments;
  logic osc_enable, low_phase, high_phase, tone_active, transmit_status_out, transmit_status_oe, mute;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 82326;
  int n, a, b;
  // keys, extra rows, mode select, disable
  logic [21:0] corner [9] = '{{16'h0000, 4'h0, 2'b10}, {16'h0000, 4'h1, 2'b10}, {16'h0000, 4'h1, 2'b00},
    {16'h0003, 4'h0, 2'b10}, {16'h0011, 4'h0, 2'b10}, {16'h0011, 4'h0, 2'b00}, {16'h0021, 4'h0, 2'b10},
    {16'h8000, 4'h0, 2'b11}, {16'h8000, 4'h0, 2'b00}};

  dtk_key_model dtk_key_model_i (.keys(keys), .extra_rows(extra_rows), .row_lines(row_lines),
    .col_lines(col_lines));
  dtk_keypad_gen dtk_keypad_gen_i (.core_clk(core_clk), .reset_n(reset_n), .row_line_in(row_lines),
    .column_line_in(col_lines), .tone_mode_select(tone_mode_select), .device_disable(device_disable),
    .pulls(pulls), .osc_enable(osc_enable), .low_segments(low_segments), .high_segments(high_segments),
    .low_phase(low_phase), .high_phase(high_phase), .tone_active(tone_active),
    .transmit_status_out(transmit_status_out), .transmit_status_oe(transmit_status_oe), .mute(mute));

  always #25 core_clk = ~core_clk;

  // a hang costs a mismatch and still reaches the report
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 98000) begin
      err_total++;
      results();
    end
  end

  // ----------------------------------------
  // compare and expectation helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one cycle of slack covers where the sampling edge falls
  task automatic chk_near(input int got, input real exp);
    total_checks++;
    if (got - exp > exp * 0.0075 + 1.0 || exp - got > exp * 0.0075 + 1.0) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, int'(exp));
    end
  endtask

  // bit 1: low group running, bit 0: high group running
  function automatic logic [1:0] exp_run(input logic [3:0] r, input logic [3:0] c, input logic ms,
    input logic dis);
    int nr, nc;
    nr = $countones(r);
    nc = $countones(c);
    if (dis || nr == 0) return 2'b00;
    if (nr == 1 && nc == 1) return 2'b11;
    if (!ms) return 2'b00;
    if (nr == 1 && (nc == 0 || nc == 2)) return 2'b10;
    if (nr == 2 && nc == 1) return 2'b01;
    return 2'b00;
  endfunction

  task automatic apply(input logic [15:0] k, input logic [3:0] xr, input logic ms, input logic dis);
    @(posedge core_clk);
    #2;
    keys = k;
    extra_rows = xr;
    tone_mode_select = ms;
    device_disable = dis;
    repeat (6) @(posedge core_clk);
    #2;
  endtask

  // cycles between the second and third step of one segment bus
  task automatic seg_gap(input bit hi, output int cnt);
    logic [8:0] last;
    for (int e = 0; e < 3; e++) begin
      last = hi ? {high_segments, high_phase} : {low_segments, low_phase};
      cnt = 0;
      while (last === (hi ? {high_segments, high_phase} : {low_segments, low_phase}) && cnt < 3000) begin
        @(posedge core_clk);
        #2;
        cnt++;
      end
    end
  endtask

  task automatic run_check(input logic [15:0] k, input logic [3:0] xr, input logic ms, input logic dis);
    logic [8:0] l0, h0;
    logic [1:0] seen, ex;
    apply(16'h0000, 4'h0, 1'b1, 1'b0);
    chk(pulls, 16'hFF00);
    chk({low_segments, high_segments}, 16'h0000);
    chk(transmit_status_out, 1'b1);
    apply(k, xr, ms, dis);
    ex = exp_run(row_lines, col_lines, ms, dis);
    seen = 2'b00;
    l0 = {low_segments, low_phase};
    h0 = {high_segments, high_phase};
    repeat (2000) begin
      @(posedge core_clk);
      #2;
      if ({low_segments, low_phase} !== l0) seen[1] = 1'b1;
      if ({high_segments, high_phase} !== h0) seen[0] = 1'b1;
    end
    chk(seen, ex);
    chk(tone_active, |ex);
    chk(osc_enable, (|row_lines) && !dis);
    if (dis) chk(pulls, 16'h0000);
    if (dis || row_lines == 4'h0 || ex == 2'b11) begin
      chk(mute, ex == 2'b11);
      chk(transmit_status_oe, ex != 2'b11);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    #2;
    reset_n = 1'b1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      apply(16'h0001 << (i * 5), 4'h0, 1'b1, 1'b0);
      seg_gap(1'b0, n);
      chk_near(n, 20.0e6 / (32.0 * LOW_HZ[i]));
      if (i == 0) begin
        seg_gap(1'b0, n);
        full_cycle(n);
        chk_near(n, 20.0e6 / LOW_HZ[0]);
      end
      seg_gap(1'b1, n);
      chk_near(n, 20.0e6 / (32.0 * HIGH_HZ[i]));
    end
    for (int j = 0; j < 9; j++) begin
      run_check(corner[j][21:6], corner[j][5:2], corner[j][1], corner[j][0]);
    end
    // random presses stay off the fourth column
    repeat (10) begin
      a = $random(seed);
      b = $random(seed);
      run_check((16'h0001 << (4 * a[1:0] + a[3:2] % 3)) | (16'h0001 << (4 * b[1:0] + b[3:2] % 3)), 4'h0,
        a[4] | a[5], a[8] & a[9]);
    end
    results();
  end

  // 32 steps of the low bus must bring it back to where it started
  task automatic full_cycle(output int cnt);
    logic [8:0] v0, v;
    int ch;
    v0 = {low_segments, low_phase};
    v = v0;
    ch = 0;
    cnt = 0;
    while (ch < 32 && cnt < 40000) begin
      @(posedge core_clk);
      #2;
      cnt++;
      if ({low_segments, low_phase} !== v) begin
        ch++;
        v = {low_segments, low_phase};
      end
    end
    chk(v, v0);
  endtask
endmodule
